/* fs_device_ctrl.sv */
// Purpose: Endpoint control, descriptor table lookup and shared packet memory
// Assumes: Serial engine and bus master share I_REF_CLK
// Notes:   Core and bus share one clock; packet memory is single port
// Operation
// - Full-speed peripheral, all four transfer types
// - Eight endpoints, programmable buffer start, length
// - Endpoint zero limited to control type
// - Double buffering only bulk/iso, never ep0
// - Enable routes line pins to transceiver
// - Core clock 48MHz, separate from bus; here core and bus share I_REF_CLK
// - 1KB window, 512 bytes real storage
// - Packet memory shared with other controller
// - Bidirectional endpoint owns transmit and receive buffers
// - Descriptor table in packet memory, start/count
// - Four 16-bit words per entry, 8-byte aligned
// - Table base from descriptor base register
// - Double buffers alternate in ping-pong order
// - One toggle hardware, other software buffer flag
// - Transmit: toggle bit 6, flag bit 14
// - Receive: toggle bit 14, flag bit 6
// - Hardware flips toggle per completed transfer
// - NAK while toggle equals flag, except first
// - OUT toggle0 flag1 uses receive descriptor
// - Bus priority, half bandwidth reserved for USB
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
module fs_device_ctrl (
  input  wire logic                 I_REF_CLK,
  input  wire logic                 I_NRST,
  input  wire logic                 I_AWVALID,
  output logic                      O_AWREADY,
  input  wire logic [10:0]          I_AWADDR,
  input  wire logic                 I_WVALID,
  output logic                      O_WREADY,
  input  wire logic [31:0]          I_WDATA,
  input  wire logic [3:0]           I_WSTRB,
  output logic                      O_BVALID,
  input  wire logic                 I_BREADY,
  output logic [1:0]                O_BRESP,
  input  wire logic                 I_ARVALID,
  output logic                      O_ARREADY,
  input  wire logic [10:0]          I_ARADDR,
  output logic                      O_RVALID,
  input  wire logic                 I_RREADY,
  output logic [31:0]               O_RDATA,
  output logic [1:0]                O_RRESP,
  input  wire logic                 I_TOKEN,
  input  wire fs_usb_pkg::xfer_t    I_TOKEN_INFO,
  output logic                      O_TOKEN_READY,
  output fs_usb_pkg::reply_t        O_REPLY,
  input  wire logic                 I_XFER_DONE,
  input  wire fs_usb_pkg::xfer_t    I_DONE_INFO,
  input  wire fs_usb_pkg::sie_mem_t I_SIE_MEM,
  output logic                      O_SIE_MEM_ACK,
  output logic [15:0]               O_SIE_RDATA,
  output logic                      O_PHY_ROUTE
);
  import fs_usb_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic             aw_held;
    logic [10:0]      aw_addr;
    logic             w_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             ar_held;
    logic             arready;
    logic [10:0]      ar_addr;
    logic             rd_wait;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [7:0][15:0] epcs;
    logic             enable;
    logic [15:0]      base;
    logic [7:0]       first_seen;
    logic             slot;
    fetch_state_t     fsm;
    xfer_t            tok;
    logic             use_rx;
    logic             start_pend;
    logic [15:0]      start;
    reply_t           reply;
    logic             tok_ready;
    logic             sie_ack;
    logic             phy_route;
  } st_t;

  st_t         st;
  st_t         next_st;
  logic [15:0] mem [0:MEM_WORDS-1];
  logic [15:0] mem_q;
  logic        mem_en;
  logic        mem_we;
  logic [7:0]  mem_addr;
  logic [15:0] mem_wdata;
  logic        wr_go;
  logic        wr_mem;
  logic        wr_lane;
  logic        sw_epcs_wr;
  logic        bus_wr_req;
  logic        bus_rd_req;
  logic        fetching;
  logic        usb_req;
  logic        usb_gnt;
  logic        bus_gnt;
  logic [15:0] tok_cs;
  logic        tok_dbl;
  logic        tok_tog;
  logic        tok_flag;
  logic        tok_nak;

  // ep0 forced control; double buffer gated
  function automatic logic [15:0] sanitize(input logic [15:0] v, input logic is_ep0);
    logic [15:0] r;
    ep_type_t    t;
    r = v & EPCS_WMASK;
    t = ep_type_t'(r[TYPE_LSB +: 2]);
    if (is_ep0) begin
      r[TYPE_LSB +: 2] = EP_CTRL;
      r[DBL_BIT]       = 1'b0;
    end else if (!(t == EP_BULK || t == EP_ISO)) begin
      r[DBL_BIT] = 1'b0;
    end
    return r;
  endfunction

  // ****************************************************************
  // Packet memory
  // ****************************************************************
  // 512 bytes, shared, 1KB window
  always_ff @(posedge I_REF_CLK) begin
    if (mem_en && mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      mem_q <= 16'h0000;
    end else if (mem_en) begin
      mem_q <= mem[mem_addr];
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st           = st;
    next_st.reply.ack = 1'b0;
    next_st.reply.nak = 1'b0;
    next_st.slot      = !st.slot;
    wr_go      = st.aw_held && st.w_held && !st.bvalid;
    wr_mem     = st.aw_addr[MEM_SEL_BIT];
    wr_lane    = |st.w_strb[1:0];
    sw_epcs_wr = wr_go && !wr_mem && (st.aw_addr[10:5] == OFS_EPCS[10:5]) && wr_lane;
    bus_wr_req = wr_go && wr_mem;
    bus_rd_req = st.ar_held && st.ar_addr[MEM_SEL_BIT] && !st.rd_wait && !st.rvalid;
    fetching   = (st.fsm == ST_FETCH_START) || (st.fsm == ST_FETCH_COUNT);
    // bus wins except in the USB slot
    usb_req    = fetching || I_SIE_MEM.req;
    usb_gnt    = usb_req && (!(bus_wr_req || bus_rd_req) || st.slot);
    bus_gnt    = (bus_wr_req || bus_rd_req) && !usb_gnt;
    mem_en     = usb_gnt || bus_gnt;
    mem_we     = 1'b0;
    mem_addr   = st.ar_addr[9:2];
    mem_wdata  = st.w_data[15:0];
    if (usb_gnt && fetching) begin
      // entry = base + ep*8 bytes; base register
      mem_addr = {6'(st.base[8:3] + {3'b000, st.tok.ep}), st.use_rx, st.fsm == ST_FETCH_COUNT};
    end else if (usb_gnt) begin
      mem_we    = I_SIE_MEM.we;
      mem_addr  = I_SIE_MEM.addr;
      mem_wdata = I_SIE_MEM.wdata;
    end else if (bus_wr_req) begin
      mem_we   = wr_lane;
      mem_addr = st.aw_addr[9:2];
    end
    next_st.sie_ack = usb_gnt && !fetching;

    if (I_AWVALID && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = I_AWADDR;
    end
    if (I_WVALID && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = I_WDATA;
      next_st.w_strb = I_WSTRB;
    end
    if (I_ARVALID && st.arready) begin
      next_st.ar_held = 1'b1;
      next_st.ar_addr = I_ARADDR;
    end

    // Register writes
    if (wr_go && !wr_mem) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      if (st.aw_addr[10:5] == OFS_EPCS[10:5]) begin
      end else if (st.aw_addr[10:2] == OFS_CTRL[10:2]) begin
        if (wr_lane) begin
          next_st.enable = st.w_data[CTRL_EN_BIT];
          if (!st.w_data[CTRL_EN_BIT]) begin
            next_st.first_seen = 8'h00;
          end
        end
      end else if (st.aw_addr[10:2] == OFS_BASE[10:2]) begin
        if (wr_lane) begin
          next_st.base = st.w_data[15:0] & BASE_WMASK;
        end
      end else begin
        next_st.bresp = RESP_SLVERR;
      end
    end else if (bus_wr_req && bus_gnt) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
    end
    if (st.bvalid && I_BREADY) begin
      next_st.bvalid  = 1'b0;
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
    end

    // Reads
    if (st.ar_held && !st.rvalid && !st.rd_wait && !st.ar_addr[MEM_SEL_BIT]) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      next_st.rdata  = 32'h0000_0000;
      if (st.ar_addr[10:5] == OFS_EPCS[10:5]) begin
        next_st.rdata[15:0] = st.epcs[st.ar_addr[4:2]];
      end else if (st.ar_addr[10:2] == OFS_CTRL[10:2]) begin
        next_st.rdata[CTRL_EN_BIT] = st.enable;
      end else if (st.ar_addr[10:2] == OFS_BASE[10:2]) begin
        next_st.rdata[15:0] = st.base;
      end else if (st.ar_addr[10:2] == OFS_STAT[10:2]) begin
        next_st.rdata[8:0] = {st.fsm != ST_IDLE, st.first_seen};
      end else begin
        next_st.rresp = RESP_SLVERR;
      end
    end
    if (bus_rd_req && bus_gnt && !bus_wr_req) begin
      next_st.rd_wait = 1'b1;
    end
    if (st.rd_wait) begin
      next_st.rd_wait = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rresp   = RESP_OKAY;
      next_st.rdata   = {16'h0000, mem_q};
    end
    if (st.rvalid && I_RREADY) begin
      next_st.rvalid  = 1'b0;
      next_st.ar_held = 1'b0;
    end

    // Endpoint control/status; a completion flip beats a same-cycle write
    for (int i = 0; i < EP_N; i++) begin
      if (sw_epcs_wr && (st.aw_addr[4:2] == 3'(i))) begin
        next_st.epcs[i] = sanitize(st.w_data[15:0], i == 0);
      end
      if (I_XFER_DONE && (I_DONE_INFO.ep == 3'(i))) begin
        next_st.first_seen[i] = 1'b1;
        if (I_DONE_INFO.dir_in) begin
          next_st.epcs[i][TX_TOG_BIT] = !st.epcs[i][TX_TOG_BIT];
        end else begin
          next_st.epcs[i][RX_TOG_BIT] = !st.epcs[i][RX_TOG_BIT];
        end
      end
    end

    tok_cs   = st.epcs[I_TOKEN_INFO.ep];
    tok_dbl  = tok_cs[DBL_BIT];
    tok_tog  = I_TOKEN_INFO.dir_in ? tok_cs[TX_TOG_BIT] : tok_cs[RX_TOG_BIT];
    tok_flag = I_TOKEN_INFO.dir_in ? tok_cs[RX_TOG_BIT] : tok_cs[TX_TOG_BIT];
    // hold off the host while buffers collide
    tok_nak  = !st.enable || (tok_dbl && st.first_seen[I_TOKEN_INFO.ep] && (tok_tog == tok_flag));

    case (st.fsm)
      ST_IDLE: begin
        if (I_TOKEN && st.tok_ready) begin
          if (tok_nak) begin
            next_st.reply.nak = 1'b1;
          end else begin
            next_st.tok = I_TOKEN_INFO;
            next_st.use_rx = tok_dbl ? (I_TOKEN_INFO.dir_in ? tok_tog : !tok_tog)
                                     : !I_TOKEN_INFO.dir_in;
            next_st.fsm = ST_FETCH_START;
          end
        end
      end
      ST_FETCH_START: begin
        if (usb_gnt) begin
          next_st.start_pend = 1'b1;
          next_st.fsm        = ST_FETCH_COUNT;
        end
      end
      ST_FETCH_COUNT: begin
        if (st.start_pend) begin
          next_st.start      = mem_q;
          next_st.start_pend = 1'b0;
        end
        if (usb_gnt) begin
          next_st.fsm = ST_REPLY;
        end
      end
      ST_REPLY: begin
        next_st.reply.ack   = 1'b1;
        next_st.reply.start = st.start;
        next_st.reply.count = mem_q;
        next_st.fsm         = ST_IDLE;
      end
      default: begin
        next_st.fsm = ST_IDLE;
      end
    endcase

    next_st.tok_ready = (next_st.fsm == ST_IDLE);
    next_st.awready   = !next_st.aw_held;
    next_st.wready    = !next_st.w_held;
    next_st.arready   = !next_st.ar_held;
    next_st.phy_route = next_st.enable;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      st      <= '0;
      st.fsm  <= ST_IDLE;
      st.epcs <= {EP_N{EPCS_RST}};
    end else begin
      st <= next_st;
    end
  end

  assign O_AWREADY     = st.awready;
  assign O_WREADY      = st.wready;
  assign O_BVALID      = st.bvalid;
  assign O_BRESP       = st.bresp;
  assign O_ARREADY     = st.arready;
  assign O_RVALID      = st.rvalid;
  assign O_RDATA       = st.rdata;
  assign O_RRESP       = st.rresp;
  assign O_TOKEN_READY = st.tok_ready;
  assign O_REPLY       = st.reply;
  assign O_SIE_MEM_ACK = st.sie_ack;
  assign O_SIE_RDATA   = mem_q;
  assign O_PHY_ROUTE   = st.phy_route;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  property p_ep0_ctrl;
    st.epcs[0][TYPE_LSB +: 2] == EP_CTRL;
  endproperty
  a_ep0_ctrl: assert property (p_ep0_ctrl) else $error("ep0 not control");

  property p_dbl_legal;
    st.epcs[0][DBL_BIT] == 1'b0 && (st.epcs[1][DBL_BIT] -> !st.epcs[1][TYPE_LSB]);
  endproperty
  a_dbl_legal: assert property (p_dbl_legal) else $error("double buffer illegal");

  property p_route;
    wr_go && !wr_mem && st.aw_addr[10:2] == OFS_CTRL[10:2] && wr_lane
      |-> ##1 st.enable == $past(st.w_data[CTRL_EN_BIT]) ##1 O_PHY_ROUTE == $past(st.enable);
  endproperty
  a_route: assert property (p_route) else $error("pin routing not following enable");

  property p_toggle;
    I_XFER_DONE && I_DONE_INFO.dir_in && I_DONE_INFO.ep == 3'd1
      |=> st.epcs[1][TX_TOG_BIT] != $past(st.epcs[1][TX_TOG_BIT]) && st.first_seen[1];
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle not flipped");

  property p_nak;
    I_TOKEN && st.tok_ready && tok_nak |=> O_REPLY.nak && !O_REPLY.ack && st.fsm == ST_IDLE;
  endproperty
  a_nak: assert property (p_nak) else $error("collision not answered with nak");

  property p_out_rx;
    I_TOKEN && st.tok_ready && !tok_nak && !I_TOKEN_INFO.dir_in && tok_dbl && !tok_tog
      |=> st.use_rx ##1 st.fsm != ST_IDLE;
  endproperty
  a_out_rx: assert property (p_out_rx) else $error("wrong buffer for out");

  property p_usb_share;
    usb_req && !usb_gnt ##1 usb_req |-> usb_gnt;
  endproperty
  a_usb_share: assert property (p_usb_share) else $error("usb slot starved");

  property p_entry_addr;
    st.fsm == ST_FETCH_START && usb_gnt
      |-> mem_addr == 8'((st.base[8:3] + st.tok.ep) * 4 + (st.use_rx ? 2 : 0));
  endproperty
  a_entry_addr: assert property (p_entry_addr) else $error("bad descriptor address");

  property p_fetch_bound;
    st.fsm == ST_FETCH_START |-> ##[1:6] O_REPLY.ack;
  endproperty
  a_fetch_bound: assert property (p_fetch_bound) else $error("descriptor fetch stuck");

  c_nak: cover property (I_TOKEN && st.tok_ready && tok_nak);
  c_ack: cover property (O_REPLY.ack && st.tok.dir_in);
  c_clash: cover property (usb_req && bus_gnt);
  c_mem_rd: cover property (st.rd_wait ##1 O_RVALID);

endmodule

/* fs_usb_pkg.sv */
// Purpose: Shared constants and types for the full-speed device endpoint buffer block
// Assumes: AXI4-Lite register port, one clock
// Notes:   Byte offsets; packet memory is 256 x 16 bit, one halfword per bus word
package fs_usb_pkg;

  // ****************************************************************
  // Clocks
  // ****************************************************************
  localparam int CORE_CLK_HZ    = 48_000_000;
  localparam int BUS_CLK_MIN_HZ = 24_000_000;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam int          ADDR_W      = 11;
  localparam int          EP_N        = 8;
  localparam int          MEM_WORDS   = 256;
  localparam int          MEM_SEL_BIT = 10;
  localparam logic [10:0] OFS_EPCS    = 11'h000;
  localparam logic [10:0] OFS_CTRL    = 11'h040;
  localparam logic [10:0] OFS_BASE    = 11'h044;
  localparam logic [10:0] OFS_STAT    = 11'h048;
  localparam logic [10:0] OFS_MEM     = 11'h400;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int          TX_TOG_BIT  = 6;
  localparam int          RX_TOG_BIT  = 14;
  localparam int          DBL_BIT     = 8;
  localparam int          TYPE_LSB    = 9;
  localparam int          CTRL_EN_BIT = 0;
  localparam logic [15:0] EPCS_WMASK  = 16'h4740;
  localparam logic [15:0] EPCS_RST    = 16'h0200;
  localparam logic [15:0] BASE_WMASK  = 16'h01F8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    EP_BULK = 2'h0,
    EP_CTRL = 2'h1,
    EP_ISO  = 2'h2,
    EP_INTR = 2'h3
  } ep_type_t;

  typedef enum logic [3:0] {
    ST_IDLE        = 4'b0001,
    ST_FETCH_START = 4'b0010,
    ST_FETCH_COUNT = 4'b0100,
    ST_REPLY       = 4'b1000
  } fetch_state_t;

  typedef struct packed {
    logic [2:0] ep;
    logic       dir_in;
  } xfer_t;

  typedef struct packed {
    logic        ack;
    logic        nak;
    logic [15:0] start;
    logic [15:0] count;
  } reply_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } sie_mem_t;

endpackage

/* sie_host_model.sv */
// Purpose: Serial engine side model issuing tokens, completions and packet memory requests
// Assumes: Shares I_REF_CLK with the block; the bench calls its tasks one at a time per port
// Notes:   Released qualifiers are driven to the inverse so stale values never look valid
`timescale 1ns/100ps
module sie_host_model (
  input  wire logic                 i_clk,
  input  wire logic                 i_tok_ready,
  input  wire fs_usb_pkg::reply_t   i_reply,
  input  wire logic                 i_mem_ack,
  input  wire logic [15:0]          i_mem_rdata,
  output logic                      o_token,
  output fs_usb_pkg::xfer_t         o_token_info,
  output logic                      o_done,
  output fs_usb_pkg::xfer_t         o_done_info,
  output fs_usb_pkg::sie_mem_t      o_mem
);
  import fs_usb_pkg::*;

  initial begin
    o_token      = 1'b0;
    o_token_info = '0;
    o_done       = 1'b0;
    o_done_info  = '0;
    o_mem        = '0;
  end

  // ****************************************************************
  // Token and completion
  // ****************************************************************
  task automatic token(input logic [2:0] ep, input logic din, output logic ack, output logic nak,
                       output logic [15:0] st, output logic [15:0] cnt);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (!i_tok_ready && n < 20);
    o_token      <= 1'b1;
    o_token_info <= '{ep, din};
    @(posedge i_clk);
    o_token      <= 1'b0;
    o_token_info <= '{~ep, ~din};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (!(i_reply.ack || i_reply.nak) && n < 12);
    ack = i_reply.ack;
    nak = i_reply.nak;
    st  = i_reply.start;
    cnt = i_reply.count;
  endtask

  task automatic done(input logic [2:0] ep, input logic din);
    @(posedge i_clk);
    o_done      <= 1'b1;
    o_done_info <= '{ep, din};
    @(posedge i_clk);
    o_done      <= 1'b0;
    o_done_info <= '{~ep, ~din};
  endtask

  // ****************************************************************
  // Packet memory port
  // ****************************************************************
  // hold until acknowledged
  task automatic mem(input logic we, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    o_mem <= '{1'b1, we, a, d};
    do begin
      @(posedge i_clk);
      n++;
    end while (!i_mem_ack && n < 20);
    q = i_mem_rdata;
    o_mem <= '{1'b0, ~we, ~a, ~d};
  endtask
endmodule

/* testbench.sv */
// Purpose: Self-checking bench for endpoint control, descriptor lookup and packet memory
// Assumes: AXI4-Lite master tasks; engine side played by sie_host_model
// Notes:   Random endpoint configs from a fixed seed; shadow state predicts every reply
`timescale 1ns/100ps
module testbench;
  import fs_usb_pkg::*;

  logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, phy_route;
  logic [10:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic        tok, tok_rdy, done, sie_ack, enabled, acked, din;
  xfer_t       tok_info, done_info;
  reply_t      reply;
  sie_mem_t    sie_mem;
  logic [15:0] sie_rdata, hw;
  logic [15:0] ep_cs [8];
  logic [15:0] desc [8][4];
  logic [7:0]  seen;
  logic [5:0]  base_f;
  integer      seed, errors, comparisons, cycles, i, k, ep, tb;

  fs_device_ctrl u_fs_device_ctrl (.I_REF_CLK(clk), .I_NRST(nrst), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_AWADDR(awaddr), .I_WVALID(wvalid), .O_WREADY(wready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp), .I_TOKEN(tok),
    .I_TOKEN_INFO(tok_info), .O_TOKEN_READY(tok_rdy), .O_REPLY(reply), .I_XFER_DONE(done),
    .I_DONE_INFO(done_info), .I_SIE_MEM(sie_mem), .O_SIE_MEM_ACK(sie_ack),
    .O_SIE_RDATA(sie_rdata), .O_PHY_ROUTE(phy_route));

  sie_host_model u_sie_host_model (.i_clk(clk), .i_tok_ready(tok_rdy), .i_reply(reply),
    .i_mem_ack(sie_ack), .i_mem_rdata(sie_rdata), .o_token(tok), .o_token_info(tok_info),
    .o_done(done), .o_done_info(done_info), .o_mem(sie_mem));

  // ****************************************************************
  // Clock, watchdog, report
  // ****************************************************************
  // one clock, no bus ratio
  always #25 clk = ~clk;

  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Ceiling well above the roughly 1300 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles > 30000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ****************************************************************
  // AXI4-Lite master
  // ****************************************************************
  task automatic axi_write(input logic [10:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; awaddr <= ~a; end
      if (!w_ok && wready) begin w_ok = 1'b1; wvalid <= 1'b0; wdata <= ~d; end
    end
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [10:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arvalid <= 1'b1; araddr <= a;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0; araddr <= ~a; rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // ****************************************************************
  // Expectations
  // ****************************************************************
  function automatic logic [15:0] exp_cs(input integer e, input logic [15:0] w);
    logic [15:0] m;
    m = w & EPCS_WMASK;
    if (e == 0) m = (m & 16'hF8FF) | 16'h0200;
    else if (m[10:9] == EP_CTRL || m[10:9] == EP_INTR) m[DBL_BIT] = 1'b0;
    return m;
  endfunction

  function automatic logic [10:0] maddr(input integer e, input logic rx, input logic c);
    logic [7:0] idx;
    idx = {base_f + 6'(e), rx, c};
    return OFS_MEM | {1'b0, idx, 2'b00};
  endfunction

  task automatic tok_check(input integer e, input logic di, output logic ok);
    logic a, n, dbl, tg, fl, rx, xn;
    logic [15:0] s, c;
    dbl = ep_cs[e][DBL_BIT];
    tg  = di ? ep_cs[e][TX_TOG_BIT] : ep_cs[e][RX_TOG_BIT];
    fl  = di ? ep_cs[e][RX_TOG_BIT] : ep_cs[e][TX_TOG_BIT];
    rx  = dbl ? (di ? tg : !tg) : !di;
    xn  = !enabled || (dbl && seen[e] && tg == fl);
    u_sie_host_model.token(3'(e), di, a, n, s, c);
    chk(n, xn);
    chk(a, !xn);
    if (!xn) chk({c, s}, {desc[e][{rx, 1'b1}], desc[e][{rx, 1'b0}]});
    ok = !xn;
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    seed = 10268; errors = 0; comparisons = 0; cycles = 0;
    clk = 1'b0; nrst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = '0; araddr = '0; wdata = '0; wstrb = '0;
    enabled = 1'b0; seen = '0; base_f = '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      axi_read(OFS_EPCS + 11'(4 * i), rd, rs);
      chk(rd, 32'h0000_0200);
      ep_cs[i] = 16'h0200;
    end
    axi_read(OFS_CTRL, rd, rs);
    chk(rd, 32'h0000_0000);
    axi_read(11'h04C, rd, rs);
    chk({rs, rd}, {RESP_SLVERR, 32'h0000_0000});
    axi_write(OFS_STAT, 32'h0000_0000, 4'hF, rs);
    chk(rs, RESP_SLVERR);
    tok_check(1, 1'b1, acked);
    chk(phy_route, 1'b0);
    axi_write(OFS_CTRL, 32'h0000_0001, 4'hF, rs);
    enabled = 1'b1;
    repeat (3) @(posedge clk);
    chk(phy_route, 1'b1);
    // Bus and engine competing for the shared memory
    fork
      u_sie_host_model.mem(1'b1, 8'hF0, 16'hA5C3, hw);
      axi_write(OFS_MEM | 11'h3C4, 32'hFFFF_1234, 4'hF, rs);
    join
    axi_read(OFS_MEM | 11'h3C0, rd, rs);
    chk(rd, 32'h0000_A5C3);
    u_sie_host_model.mem(1'b0, 8'hF1, 16'h0000, hw);
    chk(hw, 16'h1234);
    v = $random(seed);
    base_f = v[8:3];
    axi_write(OFS_BASE, v, 4'hF, rs);
    axi_read(OFS_BASE, rd, rs);
    chk(rd, {16'h0000, v[15:0] & BASE_WMASK});
    for (i = 0; i < 8; i++) begin
      for (k = 0; k < 4; k++) begin
        v = $random(seed);
        desc[i][k] = v[15:0];
        axi_write(maddr(i, k[1], k[0]), v, 4'hF, rs);
      end
    end
    axi_read(maddr(7, 1'b1, 1'b1), rd, rs);
    chk(rd, {16'h0000, desc[7][3]});
    axi_write(OFS_EPCS, 32'h0000_FFFF, 4'hF, rs);
    ep_cs[0] = exp_cs(0, 16'hFFFF);
    axi_read(OFS_EPCS, rd, rs);
    chk(rd, {16'h0000, ep_cs[0]});
    axi_write(OFS_EPCS + 11'h004, 32'h0000_4740, 4'hC, rs);
    axi_read(OFS_EPCS + 11'h004, rd, rs);
    chk({rs, rd}, {RESP_OKAY, 16'h0000, ep_cs[1]});
    for (i = 0; i < 80; i++) begin
      ep = {$random(seed)} % 8;
      if (i % 3 == 0) begin
        v = $random(seed);
        ep_cs[ep] = exp_cs(ep, v[15:0]);
        axi_write(OFS_EPCS + 11'(4 * ep), v, 4'hF, rs);
        axi_read(OFS_EPCS + 11'(4 * ep), rd, rs);
        chk(rd, {16'h0000, ep_cs[ep]});
      end
      din = $random(seed);
      tok_check(ep, din, acked);
      tb = din ? TX_TOG_BIT : RX_TOG_BIT;
      v = $random(seed);
      if (acked && v[0]) begin
        u_sie_host_model.done(3'(ep), din);
        ep_cs[ep][tb] = ~ep_cs[ep][tb];
        seen[ep] = 1'b1;
        axi_read(OFS_EPCS + 11'(4 * ep), rd, rs);
        chk(rd, {16'h0000, ep_cs[ep]});
      end else if (v[1]) begin
        ep_cs[ep][din ? RX_TOG_BIT : TX_TOG_BIT] = ~ep_cs[ep][din ? RX_TOG_BIT : TX_TOG_BIT];
        axi_write(OFS_EPCS + 11'(4 * ep), {16'h0000, ep_cs[ep]}, 4'hF, rs);
      end
    end
    axi_read(OFS_STAT, rd, rs);
    chk(rd, 32'(seen));
    axi_write(OFS_CTRL, 32'h0000_0000, 4'hF, rs);
    seen = '0;
    enabled = 1'b0;
    axi_read(OFS_STAT, rd, rs);
    chk(rd, 32'(seen));
    chk(phy_route, 1'b0);
    tok_check(2, 1'b1, acked);
    report_and_stop();
  end
endmodule
